// ===== sacc_regs.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef SACC_REGS_VH
`define SACC_REGS_VH

`define SACC_ADDR_W 8
`define SACC_OFF_MODE 8'h00
`define SACC_OFF_DIVIDE 8'h04
`define SACC_OFF_SAMPLE_TIME 8'h08
`define SACC_OFF_CHANNEL 8'h0C
`define SACC_OFF_START 8'h10
`define SACC_OFF_STATUS 8'h14
`define SACC_OFF_RESULT 8'h18
`define SACC_OFF_IRQ_STATUS 8'h1C
`define SACC_OFF_IRQ_ENABLE 8'h20
`define SACC_OFF_IRQ_CLEAR 8'h24

`define SACC_MODE_NOCAL_BIT 3
`define SACC_MODE_NOPWRDN_BIT 2
`define SACC_RES_10 2'b00
`define SACC_RES_12 2'b01
`define SACC_RES_8 2'b10

`define SACC_ST_BUSY_BIT 0
`define SACC_ST_SAMPLE_BIT 1
`define SACC_ST_VALID_BIT 2
`define SACC_ST_CAL_BIT 3
`define SACC_ST_PWRDN_BIT 4

`define SACC_IRQ_DONE_BIT 0
`define SACC_IRQ_CALDONE_BIT 1
`define SACC_IRQ_INJECT_BIT 2
`define SACC_IRQ_W 3

`define SACC_MODE_RESET 4'h0
`define SACC_DIVIDE_RESET 8'h01
`define SACC_SAMPLE_TIME_RESET 8'h03
`define SACC_CHANNEL_RESET 5'h00

`define SACC_DIV_MULT 4
`define SACC_SAMPLE_EXTRA 2
`define SACC_POSTCAL_TICKS 2
`define SACC_POWERUP_CAL_TICKS 3840

`endif

// ===== sacc_ctrl.v
// Conversion control and sequencing for a 12-bit successive approximation converter.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_regs.vh"

// Operation
// - Mode bit 3 low: two-tick post calibration
// - Mode bit 2 low: power down after conversion
// - Mode bits 1:0 pick 10, 12, 8 bits
// - Converter tick period is 4*(1+divide) cycles
// - Inputs sampled on system clock; start begins conversion
// - Sample phase raises busy and sample together
// - Sample phase lasts 2 plus sample-time ticks
// - Distribution drops sample, one tick per bit
// - Post calibration two ticks, else busy falls
// - Result valid rises as busy falls
// - Result valid holds until next start
// - Latency: sync, sample, distribution, calibration, sync
// - New start abandons conversion and restarts
// - Power-up calibration of 3840 ticks after reset
// - Result held until next result valid rise
module sacc_ctrl #(
	parameter CAL_TICKS = `SACC_POWERUP_CAL_TICKS,
	parameter RES_W = 12
) (
	// Clock and reset.
	input wire clk_sys_i,
	input wire sys_rst_i,
	// Wishbone slave.
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`SACC_ADDR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Fabric start and analog side.
	input wire conversion_start_i,
	input wire comparator_i,
	output reg [RES_W-1:0] dac_code_o,
	output reg [4:0] channel_o,
	output reg power_down_o,
	// Status.
	output reg busy_o,
	output reg sample_o,
	output reg result_valid_o,
	output reg calibrate_o,
	output reg [RES_W-1:0] result_o,
	output wire irq_o
);

	localparam ST_CAL = 3'd0;
	localparam ST_IDLE = 3'd1;
	localparam ST_SAMPLE = 3'd2;
	localparam ST_DIST = 3'd3;
	localparam ST_POST = 3'd4;

	function [3:0] res_bits;
		input [1:0] code;
		begin
			if (code == `SACC_RES_10)
				res_bits = 4'd10;
			else if (code == `SACC_RES_8)
				res_bits = 4'd8;
			else
				res_bits = 4'd12;
		end
	endfunction

	reg [3:0] mode_reg;
	reg [7:0] divide_reg;
	reg [7:0] stime_reg;
	reg [4:0] chan_reg;
	reg [`SACC_IRQ_W-1:0] irq_stat_reg;
	reg [`SACC_IRQ_W-1:0] irq_en_reg;
	reg [2:0] state_reg;
	reg [11:0] cnt_reg;
	reg [9:0] div_cnt_reg;
	reg [3:0] bit_reg;
	reg [3:0] conv_mode_reg;
	reg [11:0] sar_reg;
	reg sw_start_reg;

	wire wb_req;
	wire wb_wr;
	wire start;
	wire tick;
	wire [9:0] div_limit;
	wire [`SACC_IRQ_W-1:0] irq_set;
	wire conv_done;
	wire cal_done;
	wire inject;
	wire [11:0] sar_bit;
	wire [11:0] sar_next;
	reg [31:0] rd_data;

	assign wb_req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack.
	assign wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];

	assign start = (conversion_start_i | sw_start_reg) &
		(state_reg != ST_CAL);

	// Period of 4*(1+divide) system cycles; the count is 10 bits wide.
	assign div_limit = {divide_reg, 2'b11};
	assign tick = (div_cnt_reg == div_limit);

	assign conv_done = tick & (cnt_reg == 12'd0) &
		(((state_reg == ST_DIST) &
		conv_mode_reg[`SACC_MODE_NOCAL_BIT]) |
		(state_reg == ST_POST));
	assign cal_done = tick & (cnt_reg == 12'd0) &
		(state_reg == ST_CAL);
	assign inject = start & busy_o;

	assign sar_bit = 12'h001 << bit_reg;
	assign sar_next = comparator_i ? sar_reg : (sar_reg & ~sar_bit);

	assign irq_set[`SACC_IRQ_DONE_BIT] = conv_done;
	assign irq_set[`SACC_IRQ_CALDONE_BIT] = cal_done;
	assign irq_set[`SACC_IRQ_INJECT_BIT] = inject;
	assign irq_o = |(irq_stat_reg & irq_en_reg);

	// Register read decode.
	always @* begin
		rd_data = 32'h0000_0000;
		if (wb_adr_i == `SACC_OFF_MODE) begin
			rd_data[3:0] = mode_reg;
		end else if (wb_adr_i == `SACC_OFF_DIVIDE) begin
			rd_data[7:0] = divide_reg;
		end else if (wb_adr_i == `SACC_OFF_SAMPLE_TIME) begin
			rd_data[7:0] = stime_reg;
		end else if (wb_adr_i == `SACC_OFF_CHANNEL) begin
			rd_data[4:0] = chan_reg;
		end else if (wb_adr_i == `SACC_OFF_STATUS) begin
			rd_data[`SACC_ST_BUSY_BIT] = busy_o;
			rd_data[`SACC_ST_SAMPLE_BIT] = sample_o;
			rd_data[`SACC_ST_VALID_BIT] = result_valid_o;
			rd_data[`SACC_ST_CAL_BIT] = calibrate_o;
			rd_data[`SACC_ST_PWRDN_BIT] = power_down_o;
		end else if (wb_adr_i == `SACC_OFF_RESULT) begin
			rd_data[RES_W-1:0] = result_o;
		end else if (wb_adr_i == `SACC_OFF_IRQ_STATUS) begin
			rd_data[`SACC_IRQ_W-1:0] = irq_stat_reg;
		end else if (wb_adr_i == `SACC_OFF_IRQ_ENABLE) begin
			rd_data[`SACC_IRQ_W-1:0] = irq_en_reg;
		end
	end

	// Bus slave: every address answers, unmapped ones read zero.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req & ~wb_ack_o;
			if (wb_req & ~wb_ack_o)
				wb_dat_o <= rd_data;
		end
	end

	// Software registers and interrupt bookkeeping.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mode_reg <= `SACC_MODE_RESET;
			divide_reg <= `SACC_DIVIDE_RESET;
			stime_reg <= `SACC_SAMPLE_TIME_RESET;
			chan_reg <= `SACC_CHANNEL_RESET;
			irq_en_reg <= {`SACC_IRQ_W{1'b0}};
			irq_stat_reg <= {`SACC_IRQ_W{1'b0}};
			sw_start_reg <= 1'b0;
		end else begin
			sw_start_reg <= wb_wr & (wb_adr_i == `SACC_OFF_START) &
				wb_dat_i[0];
			if (wb_wr & (wb_adr_i == `SACC_OFF_MODE))
				mode_reg <= wb_dat_i[3:0];
			if (wb_wr & (wb_adr_i == `SACC_OFF_DIVIDE))
				divide_reg <= wb_dat_i[7:0];
			if (wb_wr & (wb_adr_i == `SACC_OFF_SAMPLE_TIME))
				stime_reg <= wb_dat_i[7:0];
			if (wb_wr & (wb_adr_i == `SACC_OFF_CHANNEL))
				chan_reg <= wb_dat_i[4:0];
			if (wb_wr & (wb_adr_i == `SACC_OFF_IRQ_ENABLE))
				irq_en_reg <= wb_dat_i[`SACC_IRQ_W-1:0];
			// A new event wins over a clear in the same cycle.
			if (wb_wr & (wb_adr_i == `SACC_OFF_IRQ_CLEAR))
				irq_stat_reg <= (irq_stat_reg &
					~wb_dat_i[`SACC_IRQ_W-1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end

	// Converter clock enable; restarted by each start so phases align.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i)
			div_cnt_reg <= 10'd0;
		else if (start | tick)
			div_cnt_reg <= 10'd0;
		else
			div_cnt_reg <= div_cnt_reg + 10'd1;
	end

	// Conversion sequencer.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_CAL;
			cnt_reg <= 12'd0;
			bit_reg <= 4'd0;
			conv_mode_reg <= `SACC_MODE_RESET;
			sar_reg <= 12'h000;
			busy_o <= 1'b0;
			sample_o <= 1'b0;
			result_valid_o <= 1'b0;
			calibrate_o <= 1'b1;
			result_o <= {RES_W{1'b0}};
			dac_code_o <= {RES_W{1'b0}};
			channel_o <= 5'd0;
			power_down_o <= 1'b0;
		end else if (start) begin
			// Injected start drops any conversion in flight.
			state_reg <= ST_SAMPLE;
			cnt_reg <= {4'd0, stime_reg} +
				12'd`SACC_SAMPLE_EXTRA - 12'd1;
			conv_mode_reg <= mode_reg;
			channel_o <= chan_reg;
			busy_o <= 1'b1;
			sample_o <= 1'b1;
			result_valid_o <= 1'b0;
			power_down_o <= 1'b0;
			sar_reg <= 12'h000;
			dac_code_o <= {RES_W{1'b0}};
		end else if (tick) begin
			case (state_reg)
			ST_CAL: begin
				// Power-up calibration counted in converter ticks.
				if (cnt_reg == CAL_TICKS[11:0] - 12'd1) begin
					state_reg <= ST_IDLE;
					calibrate_o <= 1'b0;
					cnt_reg <= 12'd0;
				end else begin
					cnt_reg <= cnt_reg + 12'd1;
				end
			end
			ST_SAMPLE: begin
				if (cnt_reg == 12'd0) begin
					state_reg <= ST_DIST;
					sample_o <= 1'b0;
					// Code 11 is reserved; it converts at 12 bits.
					cnt_reg <= {8'd0,
						res_bits(conv_mode_reg[1:0])} -
						12'd1;
					bit_reg <= 4'd11;
					sar_reg <= 12'h800;
					dac_code_o <= 12'h800;
				end else begin
					cnt_reg <= cnt_reg - 12'd1;
				end
			end
			ST_DIST: begin
				// One decision per tick, most significant bit first.
				sar_reg <= sar_next | (sar_bit >> 1);
				dac_code_o <= sar_next | (sar_bit >> 1);
				bit_reg <= bit_reg - 4'd1;
				if (cnt_reg == 12'd0) begin
					sar_reg <= sar_next;
					dac_code_o <= sar_next;
					if (conv_mode_reg[`SACC_MODE_NOCAL_BIT]) begin
						state_reg <= ST_IDLE;
						busy_o <= 1'b0;
						result_valid_o <= 1'b1;
						result_o <= sar_next;
						power_down_o <=
							~conv_mode_reg[`SACC_MODE_NOPWRDN_BIT];
					end else begin
						state_reg <= ST_POST;
						cnt_reg <= 12'd`SACC_POSTCAL_TICKS -
							12'd1;
					end
				end else begin
					cnt_reg <= cnt_reg - 12'd1;
				end
			end
			ST_POST: begin
				if (cnt_reg == 12'd0) begin
					state_reg <= ST_IDLE;
					busy_o <= 1'b0;
					result_valid_o <= 1'b1;
					result_o <= sar_reg;
					power_down_o <=
						~conv_mode_reg[`SACC_MODE_NOPWRDN_BIT];
				end else begin
					cnt_reg <= cnt_reg - 12'd1;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // sacc_ctrl
`default_nettype wire

// ===== sacc_ctrl_assertions.sv
// Port checks for the conversion controller.
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_chk #(parameter RES_W = 12) (
	// Clock, reset and bus.
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// Conversion.
	input wire conversion_start_i,
	input wire busy_o,
	input wire sample_o,
	input wire result_valid_o,
	input wire calibrate_o,
	input wire [RES_W-1:0] result_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	AST_BUSY_SAMPLE: assert property ($rose(busy_o) |-> sample_o)
		else $error("busy rose alone");
	AST_DIST_BUSY: assert property ($fell(sample_o) |-> busy_o)
		else $error("busy low at end of sample");
	AST_VALID_END: assert property ($fell(busy_o) |-> $rose(result_valid_o))
		else $error("valid not raised with busy fall");
	AST_VALID_HOLD: assert property (result_valid_o && !conversion_start_i
		|=> result_valid_o)
		else $error("valid dropped early");
	AST_RESULT_HOLD: assert property (!$rose(result_valid_o)
		|-> $stable(result_o))
		else $error("result moved");
	AST_START: assert property (conversion_start_i && !calibrate_o
		|=> busy_o && sample_o && !result_valid_o)
		else $error("start not taken");
	AST_CAL_IDLE: assert property (calibrate_o |-> !busy_o)
		else $error("busy during calibration");
	AST_SAMPLE_MIN: assert property ($rose(sample_o) |-> sample_o[*8])
		else $error("sample phase too short");
	AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	cover property ($rose(result_valid_o));
	cover property ($fell(calibrate_o));
	cover property (busy_o && conversion_start_i);
endmodule // sacc_ctrl_chk
bind sacc_ctrl sacc_ctrl_chk #(.RES_W(RES_W)) u_chk (.clk_sys_i(clk_sys_i),
	.sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .conversion_start_i(conversion_start_i),
	.busy_o(busy_o), .sample_o(sample_o), .result_valid_o(result_valid_o),
	.calibrate_o(calibrate_o), .result_o(result_o));
`default_nettype wire

// ===== sacc_fabric_model.sv
// Comparator stand-in facing the trial code output.
`timescale 1ns/1ps
`default_nettype none
module sacc_fabric_model (
	// Level and trial code.
	input wire logic [11:0] level_i,
	input wire logic [11:0] dac_code_i,
	// Answer.
	output logic comparator_o
);
	// A trial bit survives only while the code stays at or below the level.
	assign comparator_o = dac_code_i <= level_i;
endmodule // sacc_fabric_model
`default_nettype wire

// ===== sacc_ctrl_test.sv
// Self-checking bench for the conversion controller.
`timescale 1ns/1ps
`default_nettype none
`include "sacc_regs.vh"
module sacc_ctrl_test;
	logic clk_sys_i = 0;
	logic sys_rst_i = 1;
	logic cyc = 0;
	logic we = 0;
	logic st = 0;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0;
	logic [31:0] rd;
	logic [11:0] lvl = 0;
	wire [31:0] rdat;
	wire [11:0] dac;
	wire [11:0] res;
	wire [4:0] chan;
	wire ack, cmp, pd, busy, smp, vld, cal, irq;
	integer errors = 0;
	integer cmp_count = 0;
	integer seed = 32'h4f59_f0d4;
	integer d, s, n, t, m;
	integer q[$];
	sacc_ctrl #(.CAL_TICKS(4)) uut (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .conversion_start_i(st),
		.comparator_i(cmp), .dac_code_o(dac), .channel_o(chan),
		.power_down_o(pd), .busy_o(busy), .sample_o(smp),
		.result_valid_o(vld), .calibrate_o(cal), .result_o(res),
		.irq_o(irq));
	sacc_fabric_model u_far (.level_i(lvl), .dac_code_i(dac),
		.comparator_o(cmp));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	task chk(input logic [31:0] e, input logic [31:0] g, input string nm);
		cmp_count++;
		if (e !== g) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		integer k;
		k = 0;
		@(posedge clk_sys_i);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= v;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (ack !== 1'b1) begin
			errors++;
			$display("CHECK FAILED ack exp 1 got %b", ack);
		end
		rd = rdat;
		cyc <= 0;
	endtask
	task pulse;
		@(posedge clk_sys_i);
		st <= 1;
		@(posedge clk_sys_i);
		st <= 0;
	endtask
	task conv(input integer md, input integer lv, input bit inj);
		integer nb;
		integer lat;
		nb = md[1:0] == 0 ? 10 : md[1:0] == 1 ? 12 : 8;
		lat = (2 + s + nb + (md[3] ? 0 : 2)) * 4 * (d + 1);
		q.push_back((lv & 32'h0000_0fff) >> (12 - nb) << (12 - nb));
		lvl <= lv[11:0];
		if (inj)
			pulse();
		pulse();
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (vld !== 1'b1 && n < 9000);
		chk(lat + 1, n, "latency");
		chk(q.pop_front(), res, "result");
		chk(!md[2], pd, "power");
	endtask
	task close_out;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#400_000;
		errors++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		sys_rst_i <= 0;
		wb(0, `SACC_OFF_MODE, 0);
		chk(`SACC_MODE_RESET, rd, "mode");
		wb(0, `SACC_OFF_DIVIDE, 0);
		chk(`SACC_DIVIDE_RESET, rd, "divide");
		wb(0, `SACC_OFF_SAMPLE_TIME, 0);
		chk(`SACC_SAMPLE_TIME_RESET, rd, "stc");
		wb(0, 8'h3c, 0);
		chk(0, rd, "unmapped");
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (cal !== 1'b0 && n < 500);
		wb(0, `SACC_OFF_IRQ_STATUS, 0);
		chk(2, rd, "cal irq");
		wb(1, `SACC_OFF_IRQ_CLEAR, 7);
		wb(1, `SACC_OFF_IRQ_ENABLE, 1);
		for (t = 0; t < 12; t++) begin
			// Code 11 is never used; it is reserved and converts at 12 bits.
			m = t % 3 | (t / 3) << 2;
			d = 3 + t % 2;
			s = $random(seed) & 3;
			wb(1, `SACC_OFF_MODE, m);
			wb(1, `SACC_OFF_DIVIDE, d);
			wb(1, `SACC_OFF_SAMPLE_TIME, s);
			wb(1, `SACC_OFF_CHANNEL, t + 20);
			conv(m, $random(seed), t == 11);
			chk(t + 20, chan, "channel");
			chk(1, irq, "irq");
			wb(0, `SACC_OFF_STATUS, 0);
			chk(32'h0000_0004 | ((m >> 2 & 1) ^ 1) << 4, rd, "status");
			wb(1, `SACC_OFF_IRQ_CLEAR, 1);
			@(posedge clk_sys_i);
			chk(0, irq, "irq clear");
		end
		wb(0, `SACC_OFF_IRQ_STATUS, 0);
		chk(4, rd, "inject irq");
		close_out();
	end
endmodule // sacc_ctrl_test
`default_nettype wire
